// ### hdl/reg_bit_bank.sv
/*
 * One host register word built from bit cells of every access kind.
 * Assumes host_rd and host_wr are one-cycle strobes from logic on clk,
 * and that hw_set and hw_status come from logic on the same clock.
 */
`timescale 1ns/1ps
module reg_bit_bank (
	input wire logic clk,
	input wire logic rst,
	input wire logic host_rd,
	input wire logic host_wr,
	input wire logic [reg_bits_pkg::WORD_W-1:0] host_wdata,
	input wire logic [reg_bits_pkg::WORD_W-1:0] hw_set,
	input wire logic [reg_bits_pkg::WORD_W-1:0] hw_status,
	output logic [reg_bits_pkg::WORD_W-1:0] host_rdata,
	output logic host_rvalid,
	output logic [reg_bits_pkg::WORD_W-1:0] bit_q
);
	import reg_bits_pkg::*;

	logic [WORD_W-1:0] cell_q;
	logic [WORD_W-1:0] cell_d;
	logic [WORD_W-1:0] rd_val;
	logic [WORD_W-1:0] host_rdata_q;
	logic host_rvalid_q;

	////////////////////////////////////////////////////////////////////
	// Per-bit next value and read view
	generate
		for (genvar i = 0; i < WORD_W; i++) begin : g_cell
			always_comb begin
				cell_d[i] = cell_q[i];
				rd_val[i] = cell_q[i];
				case (kind_of(i))
					KIND_RO: begin
						cell_d[i] = hw_status[i];
					end
					KIND_RC: begin
						cell_d[i] = hw_set[i] | (cell_q[i] & ~host_rd);
					end
					KIND_WO: begin
						if (host_wr) begin
							cell_d[i] = host_wdata[i];
						end
						rd_val[i] = 1'b0;
					end
					KIND_W1C: begin
						cell_d[i] = hw_set[i]
							| (cell_q[i] & ~(host_wr & host_wdata[i]));
					end
					KIND_W0C: begin
						cell_d[i] = hw_set[i]
							| (cell_q[i] & ~(host_wr & ~host_wdata[i]));
					end
					KIND_LL: begin
						if (host_rd) begin
							cell_d[i] = hw_status[i];
						end else begin
							cell_d[i] = cell_q[i] & hw_status[i];
						end
					end
					KIND_LH: begin
						if (host_rd) begin
							cell_d[i] = hw_status[i];
						end else begin
							cell_d[i] = cell_q[i] | hw_status[i];
						end
					end
					KIND_SC: begin
						cell_d[i] = host_wr & host_wdata[i];
					end
					KIND_RW: begin
						if (host_wr) begin
							cell_d[i] = host_wdata[i];
						end
					end
					default: begin
						cell_d[i] = 1'b0;
						rd_val[i] = 1'b0;
					end
				endcase
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// Cell storage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cell_q <= RESET_VAL;
		end else begin
			cell_q <= cell_d;
		end
	end

	// Read data captured before the read side effects land
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			host_rdata_q <= ZERO_WORD;
		end else if (host_rd) begin
			host_rdata_q <= rd_val;
		end
	end

	// Read answer strobe
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			host_rvalid_q <= 1'b0;
		end else begin
			host_rvalid_q <= host_rd;
		end
	end

	assign host_rdata = host_rdata_q;
	assign host_rvalid = host_rvalid_q;
	assign bit_q = cell_q;

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_ro_ignores_write;
		host_wr && (host_wdata[POS_RO] != hw_status[POS_RO])
			|=> bit_q[POS_RO] != $past(host_wdata[POS_RO]);
	endproperty
	a_ro_ignores_write: assert property (p_ro_ignores_write)
		else $error("read-only bit took a host write");

	property p_rc_read_value;
		host_rd |=> host_rvalid
			&& host_rdata[POS_RC] == $past(bit_q[POS_RC]);
	endproperty
	a_rc_read_value: assert property (p_rc_read_value)
		else $error("read-to-clear bit returned wrong value");

	property p_rc_cleared;
		host_rd && !hw_set[POS_RC] |=> !bit_q[POS_RC];
	endproperty
	a_rc_cleared: assert property (p_rc_cleared)
		else $error("read-to-clear bit not cleared after read");

	property p_rc_set_wins;
		host_rd && hw_set[POS_RC] |=> bit_q[POS_RC];
	endproperty
	a_rc_set_wins: assert property (p_rc_set_wins)
		else $error("event lost on read-to-clear bit");

	property p_rc_write_ignored;
		host_wr && !host_rd && bit_q[POS_RC] |=> bit_q[POS_RC];
	endproperty
	a_rc_write_ignored: assert property (p_rc_write_ignored)
		else $error("write changed read-to-clear bit");

	property p_wo_read_zero;
		host_rd |=> host_rdata[POS_WO] == 1'b0;
	endproperty
	a_wo_read_zero: assert property (p_wo_read_zero)
		else $error("write-only bit read back nonzero");

	property p_w1c_clear;
		host_wr && host_wdata[POS_W1C] && !hw_set[POS_W1C]
			|=> !bit_q[POS_W1C];
	endproperty
	a_w1c_clear: assert property (p_w1c_clear)
		else $error("written one did not clear bit");

	property p_w1c_keep;
		host_wr && !host_wdata[POS_W1C] && bit_q[POS_W1C]
			|=> bit_q[POS_W1C];
	endproperty
	a_w1c_keep: assert property (p_w1c_keep)
		else $error("written zero cleared write-one-clear bit");

	property p_w1c_set_wins;
		hw_set[POS_W1C] |=> bit_q[POS_W1C];
	endproperty
	a_w1c_set_wins: assert property (p_w1c_set_wins)
		else $error("event lost on write-one-clear bit");

	property p_w0c_clear;
		host_wr && !host_wdata[POS_W0C] && !hw_set[POS_W0C]
			|=> !bit_q[POS_W0C];
	endproperty
	a_w0c_clear: assert property (p_w0c_clear)
		else $error("written zero did not clear bit");

	property p_w0c_keep;
		host_wr && host_wdata[POS_W0C] && bit_q[POS_W0C]
			|=> bit_q[POS_W0C];
	endproperty
	a_w0c_keep: assert property (p_w0c_keep)
		else $error("written one cleared write-zero-clear bit");

	sequence s_ll_drop;
		!hw_status[POS_LL] && !host_rd;
	endsequence
	sequence s_no_read;
		!host_rd [*3];
	endsequence
	property p_ll_hold;
		s_ll_drop ##1 s_no_read |=> !bit_q[POS_LL];
	endproperty
	a_ll_hold: assert property (p_ll_hold)
		else $error("latch-low bit released without read");

	property p_ll_release;
		host_rd |=> bit_q[POS_LL] == $past(hw_status[POS_LL]);
	endproperty
	a_ll_release: assert property (p_ll_release)
		else $error("latch-low bit not released by read");

	sequence s_lh_rise;
		hw_status[POS_LH] && !host_rd;
	endsequence
	property p_lh_hold;
		s_lh_rise ##1 s_no_read |=> bit_q[POS_LH];
	endproperty
	a_lh_hold: assert property (p_lh_hold)
		else $error("latch-high bit released without read");

	property p_lh_release;
		host_rd |=> bit_q[POS_LH] == $past(hw_status[POS_LH]);
	endproperty
	a_lh_release: assert property (p_lh_release)
		else $error("latch-high bit not released by read");

	sequence s_sc_set;
		host_wr && host_wdata[POS_SC];
	endsequence
	property p_sc_pulse;
		s_sc_set ##1 !host_wr |-> bit_q[POS_SC] ##1 !bit_q[POS_SC];
	endproperty
	a_sc_pulse: assert property (p_sc_pulse)
		else $error("self-clearing bit did not pulse once");

	property p_sc_zero_write;
		host_wr && !host_wdata[POS_SC] |=> !bit_q[POS_SC];
	endproperty
	a_sc_zero_write: assert property (p_sc_zero_write)
		else $error("zero write set self-clearing bit");

	property p_rsvd_zero;
		host_rd |=> host_rdata[WORD_W-1:POS_RW+1] == '0;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero)
		else $error("reserved bits read nonzero");

endmodule : reg_bit_bank

// ### hdl/reg_bits_pkg.sv
/*
 * Constants for the host register word bit cells: word width, bit
 * positions of each access kind, reset values and the kind table.
 * Assumes one system clock and a host port that gives one-cycle
 * read and write strobes on that clock.
 */
package reg_bits_pkg;

	localparam int WORD_W = 16;

	// Access kinds of one bit cell
	typedef enum logic [3:0] {
		KIND_RSVD = 4'h0,
		KIND_RO = 4'h1,
		KIND_RC = 4'h2,
		KIND_WO = 4'h3,
		KIND_W1C = 4'h4,
		KIND_W0C = 4'h5,
		KIND_LL = 4'h6,
		KIND_LH = 4'h7,
		KIND_SC = 4'h8,
		KIND_RW = 4'h9
	} bit_kind_t;

	// Bit positions inside the word
	localparam int POS_RO = 0;
	localparam int POS_RC = 1;
	localparam int POS_WO = 2;
	localparam int POS_W1C = 3;
	localparam int POS_W0C = 4;
	localparam int POS_LL = 5;
	localparam int POS_LH = 6;
	localparam int POS_SC = 7;
	localparam int POS_RW = 8;

	// Latch-low bit rests high; everything else rests low
	localparam logic [WORD_W-1:0] RESET_VAL = 16'h0020;
	localparam logic [WORD_W-1:0] ZERO_WORD = 16'h0000;

	// Kind table, one entry per bit position
	function automatic bit_kind_t kind_of(input int pos);
		case (pos)
			POS_RO: kind_of = KIND_RO;
			POS_RC: kind_of = KIND_RC;
			POS_WO: kind_of = KIND_WO;
			POS_W1C: kind_of = KIND_W1C;
			POS_W0C: kind_of = KIND_W0C;
			POS_LL: kind_of = KIND_LL;
			POS_LH: kind_of = KIND_LH;
			POS_SC: kind_of = KIND_SC;
			POS_RW: kind_of = KIND_RW;
			default: kind_of = KIND_RSVD;
		endcase
	endfunction : kind_of

endpackage : reg_bits_pkg

// ### verification/host_model.sv
/*
 * Host side model: one-cycle read and write strobes toward the bank.
 * Assumes the bench calls its tasks and that clk is the bank's clock.
 */
`timescale 1ns/1ps
module host_model (
	input wire logic clk,
	output logic host_rd,
	output logic host_wr,
	output logic [reg_bits_pkg::WORD_W-1:0] host_wdata
);
	import reg_bits_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Idle strobes from time zero
	initial begin
		host_rd = 1'h0;
		host_wr = 1'h0;
		host_wdata = ZERO_WORD;
	end

	task automatic wr(input logic [WORD_W-1:0] d);
		@(posedge clk);
		#2 host_wr = 1'h1;
		host_wdata = d & 16'h01FF;
		@(posedge clk);
		#2 host_wr = 1'h0;
	endtask : wr

	// One read strobe, answer due at return
	task automatic rd();
		@(posedge clk);
		#2 host_rd = 1'h1;
		@(posedge clk);
		#2 host_rd = 1'h0;
	endtask : rd
endmodule : host_model

// ### verification/reg_bit_bank_bench.sv
/*
 * Self-checking bench for the register bit bank.
 * Assumes the bank answers reads and writes one cycle after the strobe.
 */
`timescale 1ns/1ps
module reg_bit_bank_bench;
	import reg_bits_pkg::*;
	logic clk;
	logic rst;
	logic host_rd;
	logic host_wr;
	logic host_rvalid;
	logic [WORD_W-1:0] host_wdata;
	logic [WORD_W-1:0] hw_set;
	logic [WORD_W-1:0] hw_status;
	logic [WORD_W-1:0] host_rdata;
	logic [WORD_W-1:0] bit_q;
	int failures;
	int cmp_count;

	reg_bit_bank i_dut (
		.clk(clk),
		.rst(rst),
		.host_rd(host_rd),
		.host_wr(host_wr),
		.host_wdata(host_wdata),
		.hw_set(hw_set),
		.hw_status(hw_status),
		.host_rdata(host_rdata),
		.host_rvalid(host_rvalid),
		.bit_q(bit_q)
	);
	host_model i_host (
		.clk(clk),
		.host_rd(host_rd),
		.host_wr(host_wr),
		.host_wdata(host_wdata)
	);

	////////////////////////////////////////////////////////////////////
	// Clock, 25 ns period
	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end

	task automatic chk(input string n, input logic [WORD_W-1:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, exp, got);
		end
	endtask : chk

	task automatic give_verdict();
		if (failures == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict

	task automatic tick();
		@(posedge clk);
		#2;
	endtask : tick

	// Hardware event and status inputs
	task automatic drive(input logic [WORD_W-1:0] set_v, status_v);
		hw_set = set_v;
		hw_status = status_v;
	endtask : drive

	// Read, then check the answer strobe stands one cycle only
	task automatic read_word();
		i_host.rd();
		chk("rvalid high", {15'h0, host_rvalid}, 16'h0001);
		tick();
		chk("rvalid low", {15'h0, host_rvalid}, 16'h0000);
	endtask : read_word

	////////////////////////////////////////////////////////////////////
	// Read-only bit ignores writes
	task automatic t_ro();
		drive(ZERO_WORD, 16'h0021);
		i_host.wr(16'h0000);
		chk("ro high", bit_q & 16'h0001, 16'h0001);
		drive(ZERO_WORD, 16'h0020);
		i_host.wr(16'h0001);
		chk("ro low", bit_q & 16'h0001, 16'h0000);
	endtask : t_ro

	// Read-to-clear bit
	task automatic t_rc();
		drive(16'h0002, 16'h0020);
		tick();
		drive(ZERO_WORD, 16'h0020);
		i_host.wr(16'h0000);
		chk("rc kept", bit_q & 16'h0002, 16'h0002);
		read_word();
		chk("rc data", host_rdata & 16'h0002, 16'h0002);
		chk("rc clear", bit_q & 16'h0002, 16'h0000);
	endtask : t_rc

	// Clear-on-write bits, then set beating clear
	task automatic t_wclr();
		drive(16'h0018, 16'h0020);
		tick();
		drive(ZERO_WORD, 16'h0020);
		i_host.wr(16'h0010);
		chk("w1c w0c keep", bit_q & 16'h0018, 16'h0018);
		i_host.wr(16'h0008);
		chk("w1c w0c clear", bit_q & 16'h0018, 16'h0000);
		drive(16'h0008, 16'h0020);
		i_host.wr(16'h0008);
		drive(ZERO_WORD, 16'h0020);
		chk("set wins", bit_q & 16'h0008, 16'h0008);
	endtask : t_wclr

	// Latch-low and latch-high status bits, held over several idle cycles
	task automatic t_latch();
		drive(ZERO_WORD, 16'h0040);
		tick();
		drive(ZERO_WORD, 16'h0020);
		repeat (4) tick();
		chk("latched", bit_q & 16'h0060, 16'h0040);
		read_word();
		chk("latch read", host_rdata & 16'h0060, 16'h0040);
		chk("released", bit_q & 16'h0060, 16'h0020);
	endtask : t_latch

	// Self-clearing bit
	task automatic t_sc();
		i_host.wr(16'h0080);
		chk("sc set", bit_q & 16'h0080, 16'h0080);
		tick();
		chk("sc cleared", bit_q & 16'h0080, 16'h0000);
		i_host.wr(16'h0000);
		chk("sc zero write", bit_q & 16'h0080, 16'h0000);
	endtask : t_sc

	////////////////////////////////////////////////////////////////////
	// Reset for 12 cycles, then every scenario
	initial begin
		rst = 1'h1;
		drive(ZERO_WORD, 16'h0020);
		failures = 0;
		cmp_count = 0;
		repeat (12) @(posedge clk);
		#2 rst = 1'h0;
		chk("reset", bit_q, RESET_VAL);
		t_ro();
		t_rc();
		t_wclr();
		t_latch();
		t_sc();
		give_verdict();
	end
endmodule : reg_bit_bank_bench
